// ---- design/crwl_top.sv ----
// Write lock logic for the control register regions
// Notes on behaviour
// - Five lock registers, one per region
// - Locked region drops writes, contents unchanged
// - Own lock key locks, own unlock key unlocks
// - Region five locks on key 143f832c
// - Region five unlocks on key 6f361e05
// - Locked region five write errors, bus dies
`timescale 1ns/1ns
`default_nettype none
module crwl_top
    import crwl_pkg::*;
#(
    parameter logic [31:0] LOCK_KEY_0   = 32'h00000001,
    parameter logic [31:0] UNLOCK_KEY_0 = 32'h00000002,
    parameter logic [31:0] LOCK_KEY_1   = 32'h00000011,
    parameter logic [31:0] UNLOCK_KEY_1 = 32'h00000012,
    parameter logic [31:0] LOCK_KEY_2   = 32'h00000021,
    parameter logic [31:0] UNLOCK_KEY_2 = 32'h00000022,
    parameter logic [31:0] LOCK_KEY_3   = 32'h00000031,
    parameter logic [31:0] UNLOCK_KEY_3 = 32'h00000032,
    parameter logic [4:0]  RESET_LOCKED = 5'h00,
    parameter bit          MODEL_FAULT  = 1'b1
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    acc_valid,
    input  wire logic                    acc_write,
    input  wire logic                    acc_lock,
    input  wire logic [CRWL_SEL_W-1:0]   acc_region,
    input  wire logic [CRWL_DATA_W-1:0]  acc_wdata,
    output logic                         acc_done,
    output logic                         acc_error,
    output logic [CRWL_DATA_W-1:0]       acc_rdata,
    output logic                         region_write,
    output logic [CRWL_SEL_W-1:0]        region_write_sel,
    output logic [CRWL_DATA_W-1:0]       region_write_data,
    output logic [CRWL_NUM_REGIONS-1:0]  region_locked,
    output logic                         bus_dead
);
    localparam logic [31:0] LOCK_KEYS [CRWL_NUM_REGIONS] =
        '{LOCK_KEY_0, LOCK_KEY_1, LOCK_KEY_2, LOCK_KEY_3, CRWL_R5_LOCK_KEY};
    localparam logic [31:0] UNLOCK_KEYS [CRWL_NUM_REGIONS] =
        '{UNLOCK_KEY_0, UNLOCK_KEY_1, UNLOCK_KEY_2, UNLOCK_KEY_3, CRWL_R5_UNLOCK_KEY};

    crwl_bus_state_t             state;
    crwl_bus_state_t             next_state;
    logic [CRWL_DATA_W-1:0]      key_reg [CRWL_NUM_REGIONS];
    logic [CRWL_DATA_W-1:0]      next_key_reg [CRWL_NUM_REGIONS];
    logic [CRWL_NUM_REGIONS-1:0] next_region_locked;
    logic                        next_acc_done;
    logic                        next_acc_error;
    logic [CRWL_DATA_W-1:0]      next_acc_rdata;
    logic                        next_region_write;
    logic [CRWL_SEL_W-1:0]       next_region_write_sel;
    logic [CRWL_DATA_W-1:0]      next_region_write_data;
    logic                        sel_ok;
    logic                        alive_acc;

    // Out-of-range selects are answered but touch nothing
    assign sel_ok    = (acc_region < CRWL_SEL_W'(CRWL_NUM_REGIONS));
    assign alive_acc = acc_valid && (state == CRWL_ALIVE);

    genvar g;
    generate
        for (g = 0; g < CRWL_NUM_REGIONS; g++) begin : g_lock
            always_comb begin
                next_key_reg[g]       = key_reg[g];
                next_region_locked[g] = region_locked[g];
                if (alive_acc && acc_write && acc_lock &&
                    acc_region == CRWL_SEL_W'(g)) begin
                    // Other values are ignored, so a stray write cannot half-unlock
                    if (acc_wdata == LOCK_KEYS[g]) begin
                        next_key_reg[g]       = acc_wdata;
                        next_region_locked[g] = 1'b1;
                    end else if (acc_wdata == UNLOCK_KEYS[g]) begin
                        next_key_reg[g]       = acc_wdata;
                        next_region_locked[g] = 1'b0;
                    end
                end
            end
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    key_reg[g]       <= RESET_LOCKED[g] ? LOCK_KEYS[g] : UNLOCK_KEYS[g];
                    region_locked[g] <= RESET_LOCKED[g];
                end else begin
                    key_reg[g]       <= next_key_reg[g];
                    region_locked[g] <= next_region_locked[g];
                end
            end
        end
    endgenerate

    always_comb begin
        next_state             = state;
        next_acc_done          = 1'b0;
        next_acc_error         = 1'b0;
        next_acc_rdata         = CRWL_DATA_ZERO;
        next_region_write      = 1'b0;
        next_region_write_sel  = region_write_sel;
        next_region_write_data = region_write_data;
        case (state)
            CRWL_ALIVE: begin
                if (acc_valid) begin
                    next_acc_done = 1'b1;
                    if (!acc_write && acc_lock && sel_ok) begin
                        next_acc_rdata = key_reg[acc_region];
                    end
                    if (acc_write && !acc_lock && sel_ok) begin
                        if (!region_locked[acc_region]) begin
                            next_region_write      = 1'b1;
                            next_region_write_sel  = acc_region;
                            next_region_write_data = acc_wdata;
                        end else if (MODEL_FAULT &&
                                     acc_region == CRWL_SEL_W'(CRWL_FAULT_REGION)) begin
                            // Faulty silicon: error, then the whole bus hangs
                            next_acc_error = 1'b1;
                            next_state     = CRWL_DEAD;
                        end
                        // Other locked regions just drop the write
                    end
                end
            end
            CRWL_DEAD: begin
                // No answer ever again until reset
                next_state = CRWL_DEAD;
            end
            default: begin
                next_state = CRWL_DEAD;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state             <= CRWL_ALIVE;
            acc_done          <= 1'b0;
            acc_error         <= 1'b0;
            acc_rdata         <= CRWL_DATA_ZERO;
            region_write      <= 1'b0;
            region_write_sel  <= '0;
            region_write_data <= CRWL_DATA_ZERO;
            bus_dead          <= 1'b0;
        end else begin
            state             <= next_state;
            acc_done          <= next_acc_done;
            acc_error         <= next_acc_error;
            acc_rdata         <= next_acc_rdata;
            region_write      <= next_region_write;
            region_write_sel  <= next_region_write_sel;
            region_write_data <= next_region_write_data;
            bus_dead          <= (next_state == CRWL_DEAD);
        end
    end
endmodule : crwl_top
`default_nettype wire

// ---- pkg/crwl_pkg.sv ----
// Constants shared by the control region write lock block
package crwl_pkg;
    localparam int          CRWL_NUM_REGIONS  = 5;
    localparam int          CRWL_SEL_W        = 3;
    localparam int          CRWL_DATA_W       = 32;
    localparam int          CRWL_FAULT_REGION = 4;
    localparam logic [31:0] CRWL_R5_LOCK_KEY   = 32'h143f832c;
    localparam logic [31:0] CRWL_R5_UNLOCK_KEY = 32'h6f361e05;
    localparam logic [31:0] CRWL_DATA_ZERO     = 32'h00000000;
    typedef enum logic [1:0] {
        CRWL_ALIVE = 2'b00,
        CRWL_DEAD  = 2'b01
    } crwl_bus_state_t;
endpackage : crwl_pkg

// ---- tb/crwl_monitor.sv ----
// Port assertions for the write lock block
`timescale 1ns/1ns
`default_nettype none
module crwl_monitor
    import crwl_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        acc_valid,
    input wire logic        acc_write,
    input wire logic        acc_lock,
    input wire logic [2:0]  acc_region,
    input wire logic [31:0] acc_wdata,
    input wire logic        acc_done,
    input wire logic        acc_error,
    input wire logic [31:0] acc_rdata,
    input wire logic        region_write,
    input wire logic [4:0]  region_locked,
    input wire logic        bus_dead
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence req(wr, lk); acc_valid && !bus_dead && acc_write == wr && acc_lock == lk; endsequence
    sequence key5(k); req(1'b1, 1'b1) ##0 acc_region == 3'h4 && acc_wdata == k; endsequence
    AST_LOCK5: assert property (key5(CRWL_R5_LOCK_KEY) |=> region_locked[4]) else $error("no lock");
    AST_UNLOCK5: assert property (key5(CRWL_R5_UNLOCK_KEY) |=> !region_locked[4]) else $error("no unlock");
    AST_BAD_KEY: assert property (req(1'b1, 1'b1) ##0 acc_region == 3'h4 && acc_wdata != CRWL_R5_LOCK_KEY && acc_wdata != CRWL_R5_UNLOCK_KEY |=> $stable(region_locked)) else $error("bad key took");
    AST_DROP: assert property (req(1'b1, 1'b0) ##0 acc_region < 3'h4 && region_locked[acc_region] |=> acc_done && !region_write && !acc_error) else $error("locked write passed");
    AST_FWD: assert property (req(1'b1, 1'b0) ##0 acc_region < 3'h5 && !region_locked[acc_region] |=> acc_done && region_write) else $error("write not forwarded");
    AST_FAULT: assert property (req(1'b1, 1'b0) ##0 acc_region == 3'h4 && region_locked[4] |=> acc_done && acc_error && bus_dead) else $error("no bus error");
    AST_DEAD: assert property (bus_dead |=> bus_dead ##1 !acc_done) else $error("dead bus answered");
    AST_READ5: assert property (req(1'b0, 1'b1) ##0 acc_region == 3'h4 |=> acc_done && acc_rdata == (region_locked[4] ? CRWL_R5_LOCK_KEY : CRWL_R5_UNLOCK_KEY)) else $error("bad key read");
endmodule : crwl_monitor
bind crwl_top crwl_monitor u_mon (.clk(clk), .reset_n(reset_n), .acc_valid(acc_valid), .acc_write(acc_write), .acc_lock(acc_lock), .acc_region(acc_region), .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_error(acc_error), .acc_rdata(acc_rdata), .region_write(region_write), .region_locked(region_locked), .bus_dead(bus_dead));
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the write lock block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import crwl_pkg::*;
    logic        clk, reset_n, acc_valid, acc_write, acc_lock, acc_done, acc_error, region_write, bus_dead;
    logic [2:0]  acc_region, region_write_sel;
    logic [31:0] acc_wdata, acc_rdata, region_write_data;
    logic [4:0]  region_locked;
    int          fail_count = 0, total_checks = 0;
    crwl_top uut (.clk(clk), .reset_n(reset_n), .acc_valid(acc_valid), .acc_write(acc_write), .acc_lock(acc_lock), .acc_region(acc_region), .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_error(acc_error), .acc_rdata(acc_rdata), .region_write(region_write), .region_write_sel(region_write_sel), .region_write_data(region_write_data), .region_locked(region_locked), .bus_dead(bus_dead));
    task automatic chk(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk
    // One access per call, driven on falling edges only; valid stays up between calls
    task automatic acc(input logic wr, input logic lk, input logic [2:0] rg, input logic [31:0] d);
        acc_valid = 1'b1;
        acc_write = wr;
        acc_lock = lk;
        acc_region = rg;
        acc_wdata = d;
        @(posedge clk);
        @(negedge clk);
    endtask : acc
    task automatic t_low_regions();
        logic [31:0] k;
        for (int r = 0; r < 4; r++) begin
            k = 32'(r * 16 + 1);
            acc(1, 1, 3'(r), k);
            acc(1, 0, 3'(r), 32'h5a);
            chk(acc_done === 1'b1 && region_write === 1'b0 && region_locked[r] === 1'b1, "drop");
            acc(0, 1, 3'(r), 32'h0);
            chk(acc_rdata === k, "key read");
            acc(1, 1, 3'(r), k + 32'h1);
            acc(1, 0, 3'(r), k);
            chk(region_write === 1'b1 && region_write_sel === 3'(r) && region_write_data === k && region_locked === 5'h00, "fwd");
        end
    endtask : t_low_regions
    task automatic t_region5();
        acc(0, 1, 3'h4, 32'h0);
        chk(acc_rdata === CRWL_R5_UNLOCK_KEY, "reset key");
        acc(1, 1, 3'h4, 32'h143f832d);
        chk(region_locked === 5'h00, "near key");
        acc(1, 1, 3'h4, CRWL_R5_LOCK_KEY);
        acc(0, 1, 3'h4, 32'h0);
        chk(region_locked === 5'h10 && acc_rdata === CRWL_R5_LOCK_KEY, "lock");
        acc(1, 1, 3'h4, CRWL_R5_UNLOCK_KEY);
        acc(1, 0, 3'h4, 32'h77);
        chk(region_write === 1'b1 && region_write_sel === 3'h4 && acc_error === 1'b0, "unlock");
        acc(0, 0, 3'h6, 32'h0);
        chk(acc_done === 1'b1 && acc_rdata === 32'h0, "unmapped");
    endtask : t_region5
    // Must run last: the bus stays dead until reset
    task automatic t_fault();
        acc(1, 1, 3'h4, CRWL_R5_LOCK_KEY);
        acc(1, 0, 3'h4, 32'h88);
        chk(acc_done === 1'b1 && acc_error === 1'b1 && bus_dead === 1'b1 && region_write === 1'b0, "fault");
        acc(0, 1, 3'h4, 32'h0);
        chk(acc_done === 1'b0 && bus_dead === 1'b1, "dead");
    endtask : t_fault
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #20000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        {reset_n, acc_valid, acc_write, acc_lock, acc_region, acc_wdata} = '0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        t_low_regions();
        t_region5();
        t_fault();
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
